// >>> include/table_queue_pkg.sv
// constants, field layout and carrier types for the secure table/queue base registers
// assumes a 32-bit apb register window, byte addressed, one word per register
package table_queue_pkg;

  localparam int unsigned ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFF_STB_LO  = 12'h000;
  localparam logic [11:0] OFF_STB_HI  = 12'h004;
  localparam logic [11:0] OFF_STB_CFG = 12'h008;
  localparam logic [11:0] OFF_CQB_LO  = 12'h010;
  localparam logic [11:0] OFF_CQB_HI  = 12'h014;
  localparam logic [11:0] OFF_CTRL    = 12'h018;
  localparam logic [11:0] OFF_QATTR   = 12'h01c;
  localparam logic [11:0] OFF_CAPS    = 12'h020;
  localparam logic [11:0] OFF_STATUS  = 12'h024;

  // field positions
  localparam int unsigned HI_RA_POS     = 30;
  localparam int unsigned STB_ADDR_LSB  = 6;
  localparam int unsigned CQB_ADDR_LSB  = 5;
  localparam int unsigned CFG_FMT_LSB   = 16;
  localparam int unsigned CFG_SPLIT_LSB = 6;
  localparam int unsigned CTRL_XLAT_POS = 0;
  localparam int unsigned CTRL_CQEN_POS = 1;
  localparam int unsigned CTRL_REC_POS  = 2;

  // encodings and alignment figures
  localparam logic [1:0] FMT_LINEAR   = 2'h0;
  localparam logic [1:0] FMT_TWO_LVL  = 2'h1;
  localparam logic [4:0] SPLIT_4K     = 5'h06;
  localparam logic [4:0] SPLIT_16K    = 5'h08;
  localparam logic [4:0] SPLIT_64K    = 5'h0a;
  localparam logic [6:0] STB_MIN_TOP  = 7'h05;
  localparam logic [6:0] STB_LIN_ADD  = 7'h05;
  localparam logic [6:0] STB_L1_ADD   = 7'h02;
  localparam logic [6:0] CQ_MIN_TOP   = 7'h04;
  localparam logic [6:0] CQ_ENTRY_ADD = 7'h03;

  // reset values when the registers are not preset
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] table_format;
    logic [4:0] split;
    logic [5:0] log_entry_count;
  } table_cfg_type;

  typedef struct packed {
    logic        out_of_range;
    logic        two_level;
    logic [5:0]  eff_log;
    logic [5:0]  l1_count_log;
    logic [31:0] l1_index;
    logic [31:0] leaf_index;
  } index_result_type;

  // reserved split codes behave as the 4KB leaf split
  function automatic logic [4:0] split_eff(input logic [4:0] s);
    split_eff = (s == SPLIT_16K || s == SPLIT_64K) ? s : SPLIT_4K;
  endfunction : split_eff

  // zero address bits n..0
  function automatic logic [51:0] low_clear(input logic [51:0] a, input logic [6:0] n);
    low_clear = a;
    for (int i = 0; i < 52; i++) begin
      if (i <= int'(n)) begin
        low_clear[i] = 1'b0;
      end
    end
  endfunction : low_clear

endpackage : table_queue_pkg

// >>> hdl/table_index_calc.sv
// combinational source-id range check and two-level table indexing
// assumes configuration is stable register state of the same clock
`timescale 1ns/1ps
`default_nettype none
module table_index_calc (
  input  wire  table_queue_pkg::table_cfg_type    cfg,
  input  wire  logic [31:0]                       source_identifier,
  input  wire  logic [5:0]                        secure_source_id_width,
  output table_queue_pkg::index_result_type       result
);
  wire logic [5:0]  log_used;
  wire logic [4:0]  split_used;
  wire logic [31:0] leaf_mask;
  wire logic        two_lvl;

  assign log_used   = (cfg.log_entry_count < secure_source_id_width) ?
                      cfg.log_entry_count : secure_source_id_width;
  assign split_used = table_queue_pkg::split_eff(cfg.split);
  assign two_lvl    = (cfg.table_format == table_queue_pkg::FMT_TWO_LVL);
  assign leaf_mask  = ~(32'hffff_ffff << split_used);

  assign result.two_level    = two_lvl;
  assign result.eff_log      = log_used;
  assign result.out_of_range = (log_used < 6'h20) &&
                               ((source_identifier >> log_used) != 32'h0000_0000);
  // literal size: upper level holds max(1, 2^(size-split)) descriptors
  assign result.l1_count_log = ({1'b0, cfg.log_entry_count} > {2'h0, split_used}) ?
                               6'(cfg.log_entry_count - {1'b0, split_used}) : 6'h00;
  assign result.l1_index     = two_lvl ? (source_identifier >> split_used) : 32'h0000_0000;
  assign result.leaf_index   = two_lvl ? (source_identifier & leaf_mask) :
                               source_identifier;
endmodule : table_index_calc
`default_nettype wire

// >>> hdl/table_queue_regs.sv
// secure stream-table and command-queue base registers behind apb
// assumes an apb3 master on mclk and source-id requests from logic on mclk
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module table_queue_regs #(
  parameter logic        TABLES_FIXED      = 1'b0,
  parameter logic        QUEUES_FIXED      = 1'b0,
  parameter logic        LEVEL_SUPPORT     = 1'b1,
  parameter logic [5:0]  SOURCE_ID_WIDTH   = 6'h10,
  parameter logic [4:0]  MAX_CMD_QUEUE_LOG = 5'h13,
  parameter logic [63:0] PRESET_STB        = 64'h0000_0000_0000_0000,
  parameter logic [31:0] PRESET_STB_CFG    = 32'h0000_0000,
  parameter logic [63:0] PRESET_CQB        = 64'h0000_0000_0000_0000
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sid_valid,
  input  wire logic [31:0] source_identifier,
  output logic             sid_done,
  output logic             sid_abort,
  output logic             bad_source_event,
  output logic [31:0]      l1_index,
  output logic [31:0]      leaf_index,
  output logic [51:0]      table_base,
  output logic             table_read_alloc_hint,
  output logic [51:0]      cmd_queue_base,
  output logic [4:0]       cmd_queue_log,
  output logic [4:0]       cmd_queue_read_attr,
  output logic             translation_enable,
  output logic             cmd_queue_enable
);
  // register state
  logic [51:6]  stb_addr_q;
  logic         stb_ra_q;
  logic [1:0]   cfg_fmt_q;
  logic [4:0]   cfg_split_q;
  logic [5:0]   cfg_log_q;
  logic [51:5]  cqb_addr_q;
  logic         cqb_ra_q;
  logic [4:0]   cqb_log_q;
  logic         xlat_en_q;
  logic         cq_en_q;
  logic         rec_inv_q;
  logic [3:0]   qattr_q;
  // bus state
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  prdata_q;
  // derived outputs
  logic [51:0]  tbl_base_q;
  logic         tbl_ra_q;
  logic [51:0]  cq_base_q;
  logic [4:0]   cq_log_q;
  logic [4:0]   cq_rattr_q;
  logic         sid_done_q;
  logic         sid_abort_q;
  logic         bad_evt_q;
  logic [31:0]  l1_idx_q;
  logic [31:0]  leaf_idx_q;

  // bus decode
  wire logic access_wait = psel & penable & ~pready_q;
  wire logic wr_go       = psel & penable & pready_q & pwrite;
  wire logic hit_stb_lo  = (paddr == table_queue_pkg::OFF_STB_LO);
  wire logic hit_stb_hi  = (paddr == table_queue_pkg::OFF_STB_HI);
  wire logic hit_cfg     = (paddr == table_queue_pkg::OFF_STB_CFG);
  wire logic hit_cqb_lo  = (paddr == table_queue_pkg::OFF_CQB_LO);
  wire logic hit_cqb_hi  = (paddr == table_queue_pkg::OFF_CQB_HI);
  wire logic hit_ctrl    = (paddr == table_queue_pkg::OFF_CTRL);
  wire logic hit_qattr   = (paddr == table_queue_pkg::OFF_QATTR);
  wire logic hit_caps    = (paddr == table_queue_pkg::OFF_CAPS);
  wire logic hit_status  = (paddr == table_queue_pkg::OFF_STATUS);
  wire logic any_hit     = hit_stb_lo | hit_stb_hi | hit_cfg | hit_cqb_lo | hit_cqb_hi |
                           hit_ctrl | hit_qattr | hit_caps | hit_status;

  // write guards: preset registers never change, guarded ones only while off
  wire logic stb_wr_ok = ~TABLES_FIXED & ~xlat_en_q;
  wire logic cqb_wr_ok = ~QUEUES_FIXED & ~cq_en_q;

  // index and range check
  table_queue_pkg::table_cfg_type   cfg_now;
  table_queue_pkg::index_result_type idx_res;
  assign cfg_now.table_format    = cfg_fmt_q;
  assign cfg_now.split           = cfg_split_q;
  assign cfg_now.log_entry_count = cfg_log_q;

  table_index_calc u_index (
    .cfg                    (cfg_now),
    .source_identifier      (source_identifier),
    .secure_source_id_width (SOURCE_ID_WIDTH),
    .result                 (idx_res)
  );

  // stream-table effective base
  wire logic [4:0]  split_used = table_queue_pkg::split_eff(cfg_split_q);
  wire logic [6:0]  lin_top    = {1'b0, cfg_log_q} + table_queue_pkg::STB_LIN_ADD;
  wire logic [6:0]  l1_sum     = {1'b0, cfg_log_q} + table_queue_pkg::STB_L1_ADD;
  wire logic        l1_big     = l1_sum > ({2'h0, split_used} + table_queue_pkg::STB_MIN_TOP);
  wire logic [6:0]  l1_top     = l1_big ? 7'(l1_sum - {2'h0, split_used}) :
                                 table_queue_pkg::STB_MIN_TOP;
  wire logic        fmt_two    = (cfg_fmt_q == table_queue_pkg::FMT_TWO_LVL);
  wire logic [6:0]  stb_top    = fmt_two ? l1_top : lin_top;
  wire logic [51:0] stb_full   = {stb_addr_q, 6'h00};
  wire logic [51:0] stb_eff    = table_queue_pkg::low_clear(stb_full, stb_top);

  // command-queue effective base: 16-byte entries, never below 32 bytes
  wire logic [4:0]  cq_cap     = (cqb_log_q > MAX_CMD_QUEUE_LOG) ?
                                 MAX_CMD_QUEUE_LOG : cqb_log_q;
  wire logic [6:0]  cq_sum     = {2'h0, cq_cap} + table_queue_pkg::CQ_ENTRY_ADD;
  wire logic [6:0]  cq_top     = (cq_sum > table_queue_pkg::CQ_MIN_TOP) ? cq_sum :
                                 table_queue_pkg::CQ_MIN_TOP;
  wire logic [51:0] cqb_full   = {cqb_addr_q, 5'h00};
  wire logic [51:0] cqb_eff    = table_queue_pkg::low_clear(cqb_full, cq_top);

  // read data
  wire logic [31:0] rd_stb_lo  = {stb_addr_q[31:6], 6'h00};
  wire logic [31:0] rd_stb_hi  = {1'b0, stb_ra_q, 10'h000, stb_addr_q[51:32]};
  wire logic [31:0] rd_cfg     = {14'h0000, cfg_fmt_q, 5'h00, cfg_split_q, cfg_log_q};
  wire logic [31:0] rd_cqb_lo  = {cqb_addr_q[31:5], cqb_log_q};
  wire logic [31:0] rd_cqb_hi  = {1'b0, cqb_ra_q, 10'h000, cqb_addr_q[51:32]};
  wire logic [31:0] rd_ctrl    = {29'h0000_0000, rec_inv_q, cq_en_q, xlat_en_q};
  wire logic [31:0] rd_qattr   = {28'h000_0000, qattr_q};
  wire logic [31:0] rd_caps    = {13'h0000, MAX_CMD_QUEUE_LOG, 2'h0, SOURCE_ID_WIDTH,
                                  1'b0, LEVEL_SUPPORT, 1'b0, QUEUES_FIXED, 1'b0, TABLES_FIXED};
  wire logic [31:0] rd_status  = {20'h0_0000, idx_res.l1_count_log, idx_res.eff_log};
  wire logic [31:0] rd_word    = ({32{hit_stb_lo}} & rd_stb_lo) | ({32{hit_stb_hi}} & rd_stb_hi) |
                                 ({32{hit_cfg}} & rd_cfg) | ({32{hit_cqb_lo}} & rd_cqb_lo) |
                                 ({32{hit_cqb_hi}} & rd_cqb_hi) | ({32{hit_ctrl}} & rd_ctrl) |
                                 ({32{hit_qattr}} & rd_qattr) | ({32{hit_caps}} & rd_caps) |
                                 ({32{hit_status}} & rd_status);

  // write data fields; level-less parts keep format and split at zero
  wire logic [1:0]  wr_fmt   = LEVEL_SUPPORT ?
                               pwdata[table_queue_pkg::CFG_FMT_LSB +: 2] : 2'h0;
  wire logic [4:0]  wr_split = LEVEL_SUPPORT ?
                               pwdata[table_queue_pkg::CFG_SPLIT_LSB +: 5] : 5'h00;

  // apb: one wait state so read data comes from a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= table_queue_pkg::RST_ZERO;
    end else begin
      pready_q  <= access_wait;
      pslverr_q <= access_wait & ~any_hit;
      if (access_wait) begin
        prdata_q <= pwrite ? table_queue_pkg::RST_ZERO : rd_word;
      end
    end
  end

  // stream-table registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stb_addr_q  <= TABLES_FIXED ? PRESET_STB[51:6] : 46'h0;
      stb_ra_q    <= TABLES_FIXED ? PRESET_STB[62] : 1'b0;
      cfg_fmt_q   <= TABLES_FIXED ? PRESET_STB_CFG[17:16] : 2'h0;
      cfg_split_q <= TABLES_FIXED ? PRESET_STB_CFG[10:6] : 5'h00;
      cfg_log_q   <= TABLES_FIXED ? PRESET_STB_CFG[5:0] : 6'h00;
    end else if (wr_go && stb_wr_ok) begin
      if (hit_stb_lo) begin
        stb_addr_q[31:6] <= pwdata[31:table_queue_pkg::STB_ADDR_LSB];
      end
      if (hit_stb_hi) begin
        stb_addr_q[51:32] <= pwdata[19:0];
        stb_ra_q          <= pwdata[table_queue_pkg::HI_RA_POS];
      end
      if (hit_cfg) begin
        cfg_fmt_q   <= wr_fmt;
        cfg_split_q <= wr_split;
        cfg_log_q   <= pwdata[5:0];
      end
    end
  end

  // command-queue base register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cqb_addr_q <= QUEUES_FIXED ? PRESET_CQB[51:5] : 47'h0;
      cqb_ra_q   <= QUEUES_FIXED ? PRESET_CQB[62] : 1'b0;
      cqb_log_q  <= QUEUES_FIXED ? PRESET_CQB[4:0] : 5'h00;
    end else if (wr_go && cqb_wr_ok) begin
      if (hit_cqb_lo) begin
        cqb_addr_q[31:5] <= pwdata[31:table_queue_pkg::CQB_ADDR_LSB];
        cqb_log_q        <= pwdata[4:0];
      end
      if (hit_cqb_hi) begin
        cqb_addr_q[51:32] <= pwdata[19:0];
        cqb_ra_q          <= pwdata[table_queue_pkg::HI_RA_POS];
      end
    end
  end

  // control and queue attributes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xlat_en_q <= 1'b0;
      cq_en_q   <= 1'b0;
      rec_inv_q <= 1'b0;
      qattr_q   <= 4'h0;
    end else if (wr_go) begin
      if (hit_ctrl) begin
        xlat_en_q <= pwdata[table_queue_pkg::CTRL_XLAT_POS];
        cq_en_q   <= pwdata[table_queue_pkg::CTRL_CQEN_POS];
        rec_inv_q <= pwdata[table_queue_pkg::CTRL_REC_POS];
      end
      if (hit_qattr) begin
        qattr_q <= pwdata[3:0];
      end
    end
  end

  // effective bases and queue fetch attributes, registered for clean outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tbl_base_q <= 52'h0;
      tbl_ra_q   <= 1'b0;
      cq_base_q  <= 52'h0;
      cq_log_q   <= 5'h00;
      cq_rattr_q <= 5'h00;
    end else begin
      tbl_base_q <= stb_eff;
      tbl_ra_q   <= stb_ra_q;
      cq_base_q  <= cqb_eff;
      cq_log_q   <= cq_cap;
      cq_rattr_q <= {cqb_ra_q, qattr_q};
    end
  end

  // source-id check: one cycle from request to verdict
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sid_done_q  <= 1'b0;
      sid_abort_q <= 1'b0;
      bad_evt_q   <= 1'b0;
      l1_idx_q    <= 32'h0000_0000;
      leaf_idx_q  <= 32'h0000_0000;
    end else begin
      sid_done_q  <= sid_valid;
      sid_abort_q <= sid_valid & xlat_en_q & idx_res.out_of_range;
      bad_evt_q   <= sid_valid & xlat_en_q & idx_res.out_of_range & rec_inv_q;
      if (sid_valid) begin
        l1_idx_q   <= idx_res.l1_index;
        leaf_idx_q <= idx_res.leaf_index;
      end
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign sid_done              = sid_done_q;
  assign sid_abort             = sid_abort_q;
  assign bad_source_event      = bad_evt_q;
  assign l1_index              = l1_idx_q;
  assign leaf_index            = leaf_idx_q;
  assign table_base            = tbl_base_q;
  assign table_read_alloc_hint = tbl_ra_q;
  assign cmd_queue_base        = cq_base_q;
  assign cmd_queue_log         = cq_log_q;
  assign cmd_queue_read_attr   = cq_rattr_q;
  assign translation_enable    = xlat_en_q;
  assign cmd_queue_enable      = cq_en_q;
endmodule : table_queue_regs
`default_nettype wire

// >>> sim/table_queue_regs_sva.sv
// checker for the secure table/queue base registers
// assumes binding onto table_queue_regs, single mclk domain
`timescale 1ns/1ps
`default_nettype none
module table_queue_regs_chk #(
  parameter logic [4:0] MAX_CMD_QUEUE_LOG = 5'h13
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sid_valid,
  input wire logic        sid_done,
  input wire logic        sid_abort,
  input wire logic        bad_source_event,
  input wire logic        translation_enable,
  input wire logic        cmd_queue_enable,
  input wire logic [51:0] table_base,
  input wire logic        table_read_alloc_hint,
  input wire logic [51:0] cmd_queue_base,
  input wire logic [4:0]  cmd_queue_log
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_sid_latency: assert property (sid_valid |=> sid_done)
    else $error("id check late");
  a_abort_gate: assert property (sid_valid && !translation_enable |=> !sid_abort)
    else $error("abort while disabled");
  a_event_gate: assert property (bad_source_event |-> sid_abort && sid_done)
    else $error("event without abort");
  a_stb_align: assert property (table_base[5:0] == 6'h00)
    else $error("table base not aligned");
  a_cq_align: assert property (cmd_queue_base[4:0] == 5'h00 && (cmd_queue_base &
    ((52'h1 << ({1'b0, cmd_queue_log} + 6'h04)) - 52'h1)) == 52'h0)
    else $error("queue base not aligned");
  a_cq_cap: assert property (cmd_queue_log <= MAX_CMD_QUEUE_LOG)
    else $error("queue size not capped");
  a_stb_guard: assert property (translation_enable [*2] |=> $stable(table_base)
    && $stable(table_read_alloc_hint))
    else $error("table base moved while enabled");
  a_cq_guard: assert property (cmd_queue_enable [*2] |=> $stable(cmd_queue_base)
    && $stable(cmd_queue_log))
    else $error("queue base moved while enabled");
endmodule : table_queue_regs_chk
bind table_queue_regs table_queue_regs_chk #(.MAX_CMD_QUEUE_LOG(MAX_CMD_QUEUE_LOG)) chk (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sid_valid(sid_valid), .sid_done(sid_done), .sid_abort(sid_abort),
  .bad_source_event(bad_source_event), .translation_enable(translation_enable),
  .cmd_queue_enable(cmd_queue_enable), .table_base(table_base),
  .table_read_alloc_hint(table_read_alloc_hint), .cmd_queue_base(cmd_queue_base),
  .cmd_queue_log(cmd_queue_log));
`default_nettype wire

// >>> sim/tb_table_queue_regs.sv
// self-checking bench for the secure table/queue base registers
// assumes the one-wait-state apb slave and one-cycle id check
`timescale 1ns/1ps
`default_nettype none
module tb_table_queue_regs;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        sid_valid = 1'b0;
  logic [31:0] source_identifier = 32'h0000_0000;
  logic [31:0] prdata, l1_index, leaf_index;
  logic        pready, pslverr, sid_done, sid_abort, bad_source_event, hint, xen, qen;
  logic [51:0] table_base, cmd_queue_base;
  logic [4:0]  cmd_queue_log, cmd_queue_read_attr;
  logic [33:0] apb_q[$];
  logic [66:0] sid_q[$];
  logic [33:0] an;
  logic [66:0] sn;
  logic [31:0] lo, hi, v, id;
  logic [51:0] base;
  logic        two, ab;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          sp, eff, top, cap;
  table_queue_pkg::table_cfg_type c;
  localparam logic [11:0] RD0[6] = '{table_queue_pkg::OFF_STB_LO, table_queue_pkg::OFF_STB_HI,
    table_queue_pkg::OFF_STB_CFG, table_queue_pkg::OFF_CQB_LO, table_queue_pkg::OFF_CQB_HI,
    table_queue_pkg::OFF_CTRL};
  // {format, split, size}: linear, three splits, reserved split, reserved format
  localparam logic [12:0] CFG[6] = '{13'h0004, 13'h0994, 13'h0a14, 13'h0a94, 13'h09d4, 13'h1814};
  localparam int QS[3] = '{0, 8, 31};

  table_queue_regs uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sid_valid(sid_valid), .source_identifier(source_identifier),
    .sid_done(sid_done), .sid_abort(sid_abort), .bad_source_event(bad_source_event),
    .l1_index(l1_index), .leaf_index(leaf_index), .table_base(table_base),
    .table_read_alloc_hint(hint), .cmd_queue_base(cmd_queue_base),
    .cmd_queue_log(cmd_queue_log), .cmd_queue_read_attr(cmd_queue_read_attr),
    .translation_enable(xen), .cmd_queue_enable(qen));

  always #5 mclk = ~mclk;

  function automatic logic [51:0] clr(input logic [51:0] a, input int t);
    clr = a & ~((52'h1 << (t + 1)) - 52'h1);
  endfunction : clr

  task automatic check(input string what, input logic [66:0] exp, input logic [66:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    apb_q.push_back({~wr, err, d});
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // valid stays high between calls so requests go back to back
  task automatic sid(input logic [31:0] i, input logic ab_e, input logic ev, input logic ci,
                     input logic [31:0] l1, input logic [31:0] lf);
    @(posedge mclk);
    sid_valid <= 1'b1;
    source_identifier <= i;
    sid_q.push_back({ci, ab_e, ev, l1, lf});
  endtask : sid

  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      an = apb_q.pop_front();
      check("pslverr", 67'(an[32]), 67'(pslverr));
      if (an[33] === 1'b1) check("prdata", 67'(an[31:0]), 67'(prdata));
    end
    if (sid_done === 1'b1) begin
      sn = sid_q.pop_front();
      check("sid_abort", 67'(sn[65]), 67'(sid_abort));
      check("bad_source_event", 67'(sn[64]), 67'(bad_source_event));
      if (sn[66] === 1'b1) check("indices", 67'(sn[63:0]), 67'({l1_index, leaf_index}));
    end
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h8184a3a6));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (RD0[i]) apb(1'b0, RD0[i], 32'h0, 1'b0);
    apb(1'b0, 12'h0fc, 32'h0, 1'b1);
    apb(1'b1, 12'h0fc, 32'h1, 1'b1);
    apb(1'b0, table_queue_pkg::OFF_CAPS, 32'h0004_c410, 1'b0);
    lo = $urandom | 32'h0000_003f;
    hi = $urandom | 32'hc000_0000;
    apb(1'b1, table_queue_pkg::OFF_STB_LO, lo, 1'b0);
    apb(1'b1, table_queue_pkg::OFF_STB_HI, hi, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_STB_LO, lo & 32'hffff_ffc0, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_STB_HI, hi & 32'h400f_ffff, 1'b0);
    check("hint", 67'(1'b1), 67'(hint));
    base = {hi[19:0], lo[31:6], 6'h00};
    for (int i = 0; i < 6; i++) begin
      c = CFG[i];
      v = {14'h0, c.table_format, 5'h0, c.split, c.log_entry_count};
      apb(1'b1, table_queue_pkg::OFF_CTRL, 32'h0, 1'b0);
      apb(1'b1, table_queue_pkg::OFF_STB_CFG, v, 1'b0);
      apb(1'b0, table_queue_pkg::OFF_STB_CFG, v, 1'b0);
      two = (c.table_format == 2'h1);
      sp = (c.split == 5'h08 || c.split == 5'h0a) ? int'(c.split) : 6;
      eff = (c.log_entry_count > 6'h10) ? 16 : int'(c.log_entry_count);
      top = two ? int'(c.log_entry_count) + 2 - sp : int'(c.log_entry_count) + 5;
      if (top < 5) top = 5;
      check("table_base", 67'(clr(base, top)), 67'(table_base));
      apb(1'b0, table_queue_pkg::OFF_STATUS, {20'h0, 6'((c.log_entry_count > sp) ?
          int'(c.log_entry_count) - sp : 0), 6'(eff)}, 1'b0);
      // record bit alternates so the event shows both ways
      apb(1'b1, table_queue_pkg::OFF_CTRL, {29'h0, i[0], 2'h1}, 1'b0);
      for (int k = 0; k < 3; k++) begin
        id = (k == 0) ? ($urandom & ((32'h1 << eff) - 1)) : (32'h1 << eff) - 2 + k;
        ab = (k == 2);
        sid(id, ab, ab & i[0], !ab, two ? id >> sp : 32'h0,
            two ? id & ((32'h1 << sp) - 1) : id);
      end
      @(posedge mclk);
      sid_valid <= 1'b0;
      check("translation_enable", 67'(1'b1), 67'(xen));
    end
    apb(1'b1, table_queue_pkg::OFF_STB_LO, ~lo, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_STB_LO, lo & 32'hffff_ffc0, 1'b0);
    apb(1'b1, table_queue_pkg::OFF_STB_CFG, 32'h0, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_STB_CFG, v, 1'b0);
    apb(1'b1, table_queue_pkg::OFF_CTRL, 32'h0, 1'b0);
    // out-of-range id with translation off must not abort
    sid(32'hffff_ffff, 1'b0, 1'b0, 1'b1, 32'h0, 32'hffff_ffff);
    @(posedge mclk);
    sid_valid <= 1'b0;
    hi = $urandom | 32'h4000_0000;
    apb(1'b1, table_queue_pkg::OFF_QATTR, 32'h0000_000a, 1'b0);
    apb(1'b1, table_queue_pkg::OFF_CQB_HI, hi, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_CQB_HI, hi & 32'h400f_ffff, 1'b0);
    foreach (QS[j]) begin
      lo = ($urandom & 32'hffff_ffe0) | QS[j];
      apb(1'b1, table_queue_pkg::OFF_CQB_LO, lo, 1'b0);
      apb(1'b0, table_queue_pkg::OFF_CQB_LO, lo, 1'b0);
      cap = (QS[j] > 19) ? 19 : QS[j];
      top = (cap + 3 < 4) ? 4 : cap + 3;
      repeat (2) @(posedge mclk);
      check("cmd_queue_log", 67'(cap), 67'(cmd_queue_log));
      check("cmd_queue_base", 67'(clr({hi[19:0], lo[31:5], 5'h0}, top)),
            67'(cmd_queue_base));
      check("cmd_queue_read_attr", 67'(5'h1a), 67'(cmd_queue_read_attr));
    end
    apb(1'b1, table_queue_pkg::OFF_CTRL, 32'h2, 1'b0);
    apb(1'b1, table_queue_pkg::OFF_CQB_LO, ~lo, 1'b0);
    apb(1'b0, table_queue_pkg::OFF_CQB_LO, lo, 1'b0);
    check("cmd_queue_enable", 67'(1'b1), 67'(qen));
    check("translation_enable", 67'(1'b0), 67'(xen));
    // let the last answer reach the monitor before the queues are judged
    repeat (2) @(posedge mclk);
    check("pending", 67'(0), 67'(apb_q.size() + sid_q.size()));
    end_of_test();
  end
endmodule : tb_table_queue_regs
`default_nettype wire
